// ### serial_flash_pin_interface.v
// Serial flash pin engine: frame decode, lane shifting, pause and reset pin
`timescale 1ns/1ps
`include "serial_flash_defines.vh"

// How it works
// - Select high: ignore clock and data pins, release lanes
// - Deselected and idle means standby power
// - No instruction before a select falling edge
// - Inputs sampled on serial clock rising edges
// - Outputs change only after falling edges
// - Dual and quad lanes are bidirectional
// - Protect pin plus lock bits block status writes
// - Same condition locks protected array region
// - Quad enable turns protect pin into lane2
// - Fourth pin pauses or resets unless quad
// - Pause stops serial traffic, not internal work
// - Pause starts with select low, clock low
// - Pause ends while clock low, or at once on deselect
// - Quad command mode: instruction in two clocks
// - Continuous read skips instruction, eight clocks
// - Identification and three security areas readable
// - Clock modes 0 and 3 both accepted
// - Quad instructions need quad enable set
// - Reset returns to normal command mode
module serial_flash_pin_interface
(
  input  wire        core_clk,
  input  wire        rst_b,
  input  wire        chip_select_n,
  input  wire        serial_clock,
  input  wire [3:0]  lane_in,
  output reg  [3:0]  lane_out,
  output wire [3:0]  lane_oe_n,
  input  wire [7:0]  status_reg_one,
  input  wire [7:0]  status_reg_two,
  input  wire        pause_or_reset_select,
  input  wire        internal_busy,
  output wire        standby,
  output wire        status_write_locked,
  output wire        array_write_locked,
  output reg         paused,
  output reg         hw_reset,
  output reg         quad_command_mode,
  output reg         execute_from_flash,
  output reg         cmd_valid,
  output reg  [7:0]  cmd_code,
  output reg         xfer_end,
  output reg         mem_rd,
  output reg         mem_wr,
  output reg         status_wr,
  output reg  [1:0]  mem_space,
  output reg  [23:0] mem_addr,
  output reg  [7:0]  mem_wdata,
  input  wire [7:0]  mem_rdata
);

  wire [5:0] pin_s;
  wire       cs_s    = pin_s[5];
  wire       sclk_s  = pin_s[4];
  wire [3:0] lane_s  = pin_s[3:0];
  wire       pause_s = pin_s[3];
  wire       pause_func_en;
  wire       reset_func_en;
  wire       quad_lane_enable = status_reg_two[`SR2_QUAD_BIT];

  reg [2:0]  state;
  reg        sclk_d;
  reg        cs_d;
  reg [31:0] shreg;
  reg [5:0]  cnt;
  reg        reset_armed;
  reg        byte_seen;
  reg        drv_en;
  reg [2:0]  cur_aw;
  reg [2:0]  cur_dw;
  reg        cur_mode;
  reg [3:0]  cur_dummy;
  reg [1:0]  cur_dir;
  reg        cur_sw;

  // ============================================================
  // Pin synchroniser and protect logic
  pin_sync u_sync
  (
    .core_clk     (core_clk),
    .rst_b        (rst_b),
    .pin_raw      ({chip_select_n, serial_clock, lane_in}),
    .pin_sync_out (pin_s)
  );

  lock_logic u_lock
  (
    .core_clk              (core_clk),
    .rst_b                 (rst_b),
    .status_reg_one        (status_reg_one),
    .status_reg_two        (status_reg_two),
    .pause_or_reset_select (pause_or_reset_select),
    .write_protect_n       (lane_s[2]),
    .cs_n_sync             (cs_s),
    .internal_busy         (internal_busy),
    .status_write_locked   (status_write_locked),
    .array_write_locked    (array_write_locked),
    .pause_func_en         (pause_func_en),
    .reset_func_en         (reset_func_en),
    .standby               (standby)
  );

  // ============================================================
  // Edge detection
  // Edges seen while paused are dropped, so the bit position survives
  wire sclk_rise = sclk_s & ~sclk_d & ~paused;
  wire sclk_fall = ~sclk_s & sclk_d & ~paused;
  wire cs_fall   = cs_d & ~cs_s;
  wire pause_req = pause_func_en & ~cs_s & ~pause_s;
  wire reset_req = reset_func_en & ~pause_s;

  // ============================================================
  // Lane width helpers
  function [31:0] shift_in;
    input [31:0] sh;
    input [2:0]  w;
    input [3:0]  l;
    begin
      case (w)
        3'h4:    shift_in = {sh[27:0], l};
        3'h2:    shift_in = {sh[29:0], l[1:0]};
        default: shift_in = {sh[30:0], l[0]};
      endcase
    end
  endfunction

  function [3:0] lane_bits;
    input [7:0] b;
    input [2:0] w;
    begin
      case (w)
        3'h4:    lane_bits = b[7:4];
        3'h2:    lane_bits = {2'h0, b[7:6]};
        default: lane_bits = {2'h0, b[7], 1'b0};
      endcase
    end
  endfunction

  function [3:0] lane_mask;
    input [2:0] w;
    begin
      case (w)
        3'h4:    lane_mask = 4'hF;
        3'h2:    lane_mask = 4'h3;
        default: lane_mask = 4'h2;
      endcase
    end
  endfunction

  // Single lane output uses lane1; wider modes turn lanes around
  assign lane_oe_n = ~({4{drv_en}} & lane_mask(cur_dw));

  // ============================================================
  // Instruction decode
  reg  [2:0]  in_w;
  wire [31:0] sh_next = shift_in(shreg, in_w, lane_s);
  wire [2:0]  cmd_w   = quad_command_mode ? 3'h4 : 3'h1;
  wire [2:0]  wide_w  = quad_command_mode ? 3'h4 : 3'h1;
  reg         d_ok;
  reg         d_addr;
  reg         d_mode;
  reg  [2:0]  d_aw;
  reg  [2:0]  d_dw;
  reg  [3:0]  d_dummy;
  reg  [1:0]  d_dir;
  reg  [1:0]  d_space;
  reg         d_sw;

  always @*
  begin
    case (state)
      `ST_CMD:  in_w = cmd_w;
      `ST_ADDR: in_w = cur_aw;
      default:  in_w = cur_dw;
    endcase
  end

  always @*
  begin
    d_ok    = 1'b1;
    d_addr  = 1'b1;
    d_mode  = 1'b0;
    d_aw    = wide_w;
    d_dw    = wide_w;
    d_dummy = 4'h0;
    d_dir   = `DIR_OUT;
    d_space = `SPACE_ARRAY;
    d_sw    = 1'b0;
    case (sh_next[7:0])
      `OP_READ:         d_ok = ~quad_command_mode;
      `OP_FAST_READ:    d_dummy = `FAST_DUMMY;
      `OP_DUAL_OUT:
      begin
        d_ok    = ~quad_command_mode;
        d_aw    = 3'h1;
        d_dw    = 3'h2;
        d_dummy = `FAST_DUMMY;
      end
      `OP_QUAD_OUT:
      begin
        d_ok    = quad_lane_enable & ~quad_command_mode;
        d_aw    = 3'h1;
        d_dw    = 3'h4;
        d_dummy = `FAST_DUMMY;
      end
      `OP_DUAL_IO:
      begin
        d_ok   = ~quad_command_mode;
        d_aw   = 3'h2;
        d_dw   = 3'h2;
        d_mode = 1'b1;
      end
      `OP_QUAD_IO:
      begin
        d_ok    = quad_lane_enable;
        d_aw    = 3'h4;
        d_dw    = 3'h4;
        d_mode  = 1'b1;
        d_dummy = `QUAD_IO_DUMMY;
      end
      `OP_PROGRAM:      d_dir = `DIR_IN;
      `OP_QUAD_PROGRAM:
      begin
        d_ok  = quad_lane_enable & ~quad_command_mode;
        d_aw  = 3'h1;
        d_dw  = 3'h4;
        d_dir = `DIR_IN;
      end
      `OP_READ_ID:      d_space = `SPACE_ID;
      `OP_JEDEC_ID:
      begin
        d_addr  = 1'b0;
        d_space = `SPACE_JEDEC;
      end
      `OP_SEC_READ:
      begin
        d_dummy = `FAST_DUMMY;
        d_space = `SPACE_SECURITY;
      end
      `OP_WR_STATUS1, `OP_WR_STATUS2, `OP_WR_STATUS3:
      begin
        d_addr = 1'b0;
        d_dir  = `DIR_IN;
        d_sw   = 1'b1;
      end
      default:
      begin
        d_addr = 1'b0;
        d_dir  = `DIR_NONE;
      end
    endcase
  end

  // ============================================================
  // Pause tracking and reset pin
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclk_d   <= 1'b0;
      cs_d     <= 1'b0;
      paused   <= 1'b0;
      hw_reset <= 1'b0;
    end
    else
    begin
      sclk_d   <= sclk_s;
      cs_d     <= cs_s;
      hw_reset <= reset_req;
      // The start of a pause and its release by the pin wait for a low clock; deselect ends it at once
      if (cs_s)
        paused <= 1'b0;
      else if (!sclk_s)
        paused <= pause_req;
    end
  end

  // ============================================================
  // Frame engine
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state              <= `ST_IDLE;
      shreg              <= 32'h00000000;
      cnt                <= 6'h00;
      reset_armed        <= 1'b0;
      byte_seen          <= 1'b0;
      drv_en             <= 1'b0;
      lane_out           <= 4'h0;
      cur_aw             <= 3'h1;
      cur_dw             <= 3'h1;
      cur_mode           <= 1'b0;
      cur_dummy          <= 4'h0;
      cur_dir            <= `DIR_NONE;
      cur_sw             <= 1'b0;
      quad_command_mode  <= 1'b0;
      execute_from_flash <= 1'b0;
      cmd_valid          <= 1'b0;
      cmd_code           <= 8'h00;
      xfer_end           <= 1'b0;
      mem_rd             <= 1'b0;
      mem_wr             <= 1'b0;
      status_wr          <= 1'b0;
      mem_space          <= `SPACE_ARRAY;
      mem_addr           <= 24'h000000;
      mem_wdata          <= 8'h00;
    end
    else
    begin
      cmd_valid <= 1'b0;
      xfer_end  <= 1'b0;
      mem_rd    <= 1'b0;
      mem_wr    <= 1'b0;
      status_wr <= 1'b0;
      if (hw_reset)
      begin
        state              <= `ST_IDLE;
        drv_en             <= 1'b0;
        quad_command_mode  <= 1'b0;
        execute_from_flash <= 1'b0;
        reset_armed        <= 1'b0;
      end
      else if (cs_s)
      begin
        state  <= `ST_IDLE;
        drv_en <= 1'b0;
        if (state != `ST_IDLE)
          xfer_end <= 1'b1;
      end
      else if (cs_fall)
      begin
        // Any clock level at this edge is fine: only later edges count
        cnt       <= 6'h00;
        shreg     <= 32'h00000000;
        byte_seen <= 1'b0;
        state     <= execute_from_flash ? `ST_ADDR : `ST_CMD;
      end
      else
      begin
        case (state)
          `ST_CMD:
          begin
            if (sclk_rise)
            begin
              shreg <= sh_next;
              cnt   <= cnt + {3'h0, cmd_w};
              if (cnt + {3'h0, cmd_w} == `CMD_BITS)
              begin
                cmd_valid <= 1'b1;
                cmd_code  <= sh_next[7:0];
                cnt       <= 6'h00;
                reset_armed <= (sh_next[7:0] == `OP_RESET_ENABLE);
                if (sh_next[7:0] == `OP_ENTER_QCM && quad_lane_enable)
                  quad_command_mode <= 1'b1;
                if (sh_next[7:0] == `OP_EXIT_QCM)
                  quad_command_mode <= 1'b0;
                if (sh_next[7:0] == `OP_RESET_DEVICE && reset_armed)
                begin
                  quad_command_mode  <= 1'b0;
                  execute_from_flash <= 1'b0;
                end
                cur_aw    <= d_aw;
                cur_dw    <= d_dw;
                cur_mode  <= d_mode;
                cur_dummy <= d_dummy;
                cur_dir   <= d_dir;
                cur_sw    <= d_sw;
                mem_space <= d_space;
                mem_addr  <= 24'h000000;
                if (!d_ok || d_dir == `DIR_NONE)
                  state <= `ST_SKIP;
                else if (d_addr)
                  state <= `ST_ADDR;
                else if (d_dir == `DIR_OUT)
                begin
                  state  <= `ST_DOUT;
                  mem_rd <= 1'b1;
                end
                else
                  state <= `ST_DIN;
              end
            end
          end
          `ST_ADDR:
          begin
            if (sclk_rise)
            begin
              shreg <= sh_next;
              cnt   <= cnt + {3'h0, cur_aw};
              if (cnt + {3'h0, cur_aw} == (cur_mode ? `ADDR_MODE_BITS : `ADDR_BITS))
              begin
                cnt      <= 6'h00;
                mem_addr <= cur_mode ? sh_next[31:8] : sh_next[23:0];
                if (cur_mode)
                  execute_from_flash <= (sh_next[5:4] == `CONT_MODE);
                if (cur_dummy != 4'h0)
                  state <= `ST_DUMMY;
                else if (cur_dir == `DIR_OUT)
                begin
                  state  <= `ST_DOUT;
                  mem_rd <= 1'b1;
                end
                else
                  state <= `ST_DIN;
              end
            end
          end
          `ST_DUMMY:
          begin
            if (sclk_rise)
            begin
              cnt <= cnt + 6'h01;
              if (cnt + 6'h01 == {2'h0, cur_dummy})
              begin
                cnt    <= 6'h00;
                state  <= `ST_DOUT;
                mem_rd <= 1'b1;
              end
            end
          end
          `ST_DIN:
          begin
            if (sclk_rise)
            begin
              shreg <= sh_next;
              cnt   <= cnt + {3'h0, cur_dw};
              if (cnt == 6'h00 && byte_seen)
                mem_addr <= mem_addr + 24'h000001;
              if (cnt + {3'h0, cur_dw} == `CMD_BITS)
              begin
                cnt       <= 6'h00;
                byte_seen <= 1'b1;
                mem_wdata <= sh_next[7:0];
                if (cur_sw)
                  status_wr <= ~status_write_locked;
                else
                  mem_wr <= 1'b1;
              end
            end
          end
          `ST_DOUT:
          begin
            // Next byte is fetched while this one shifts out
            if (sclk_fall)
            begin
              drv_en <= 1'b1;
              if (cnt == 6'h00)
              begin
                lane_out    <= lane_bits(mem_rdata, cur_dw);
                shreg[7:0]  <= mem_rdata << cur_dw;
                cnt         <= `CMD_BITS - {3'h0, cur_dw};
                mem_rd      <= 1'b1;
                mem_addr    <= mem_addr + 24'h000001;
              end
              else
              begin
                lane_out   <= lane_bits(shreg[7:0], cur_dw);
                shreg[7:0] <= shreg[7:0] << cur_dw;
                cnt        <= cnt - {3'h0, cur_dw};
              end
            end
          end
          `ST_SKIP:
          begin
            drv_en <= 1'b0;
          end
          default:
          begin
            drv_en <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // serial_flash_pin_interface

// ### serial_flash_defines.vh
// Shared constants for the serial flash pin interface
`ifndef SERIAL_FLASH_DEFINES_VH
`define SERIAL_FLASH_DEFINES_VH

// ============================================================
// Frame states
`define ST_IDLE          3'h0
`define ST_CMD           3'h1
`define ST_ADDR          3'h2
`define ST_DUMMY         3'h3
`define ST_DIN           3'h4
`define ST_DOUT          3'h5
`define ST_SKIP          3'h6

// ============================================================
// Data direction and read space
`define DIR_NONE         2'h0
`define DIR_IN           2'h1
`define DIR_OUT          2'h2
`define SPACE_ARRAY      2'h0
`define SPACE_ID         2'h1
`define SPACE_SECURITY   2'h2
`define SPACE_JEDEC      2'h3

// ============================================================
// Instruction codes
`define OP_READ          8'h03
`define OP_FAST_READ     8'h0B
`define OP_DUAL_OUT      8'h3B
`define OP_QUAD_OUT      8'h6B
`define OP_DUAL_IO       8'hBB
`define OP_QUAD_IO       8'hEB
`define OP_PROGRAM       8'h02
`define OP_QUAD_PROGRAM  8'h32
`define OP_READ_ID       8'h90
`define OP_JEDEC_ID      8'h9F
`define OP_SEC_READ      8'h48
`define OP_WR_STATUS1    8'h01
`define OP_WR_STATUS2    8'h31
`define OP_WR_STATUS3    8'h11
`define OP_ENTER_QCM     8'h38
`define OP_EXIT_QCM      8'hFF
`define OP_RESET_ENABLE  8'h66
`define OP_RESET_DEVICE  8'h99

// ============================================================
// Status bit positions
`define SR1_LOCK_LO_BIT  7
`define SR2_LOCK_HI_BIT  0
`define SR2_QUAD_BIT     1

// ============================================================
// Frame sizes and reset values
`define CMD_BITS         6'h08
`define ADDR_BITS        6'h18
`define ADDR_MODE_BITS   6'h20
`define FAST_DUMMY       4'h8
`define QUAD_IO_DUMMY    4'h4
`define CONT_MODE        2'h2
`define PIN_SYNC_RESET   6'h0C

`endif

// ### pin_sync.v
// Two-flop synchroniser for the flash pins
`timescale 1ns/1ps
`include "serial_flash_defines.vh"

module pin_sync
(
  input  wire       core_clk,
  input  wire       rst_b,
  input  wire [5:0] pin_raw,
  output reg  [5:0] pin_sync_out
);

  reg [5:0] stage_one;

  // ============================================================
  // Synchroniser
  // First stage feeds only the second; chip select resets low so a host
  // that holds it low through power-up never fakes a falling edge.
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage_one    <= `PIN_SYNC_RESET;
      pin_sync_out <= `PIN_SYNC_RESET;
    end
    else
    begin
      stage_one    <= pin_raw;
      pin_sync_out <= stage_one;
    end
  end

endmodule // pin_sync

// ### lock_logic.v
// Write protect, pause/reset pin role and power state
`timescale 1ns/1ps
`include "serial_flash_defines.vh"

module lock_logic
(
  input  wire       core_clk,
  input  wire       rst_b,
  input  wire [7:0] status_reg_one,
  input  wire [7:0] status_reg_two,
  input  wire       pause_or_reset_select,
  input  wire       write_protect_n,
  input  wire       cs_n_sync,
  input  wire       internal_busy,
  output reg        status_write_locked,
  output reg        array_write_locked,
  output reg        pause_func_en,
  output reg        reset_func_en,
  output reg        standby
);

  wire quad_lane_enable = status_reg_two[`SR2_QUAD_BIT];
  wire status_lock_hi   = status_reg_two[`SR2_LOCK_HI_BIT];
  wire status_lock_lo   = status_reg_one[`SR1_LOCK_LO_BIT];
  // Quad lanes turn the protect pin into a data lane
  wire hw_lock = ~quad_lane_enable & ~write_protect_n & ~status_lock_hi & status_lock_lo;

  // ============================================================
  // Registered status
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      status_write_locked <= 1'b0;
      array_write_locked  <= 1'b0;
      pause_func_en       <= 1'b0;
      reset_func_en       <= 1'b0;
      standby             <= 1'b0;
    end
    else
    begin
      status_write_locked <= hw_lock;
      array_write_locked  <= hw_lock;
      pause_func_en       <= ~quad_lane_enable & ~pause_or_reset_select;
      reset_func_en       <= ~quad_lane_enable & pause_or_reset_select;
      standby             <= cs_n_sync & ~internal_busy;
    end
  end

endmodule // lock_logic

// ### serial_flash_pin_interface_checker.sv
// Port assertions for the flash pin engine
`timescale 1ns/1ps
module serial_flash_pin_interface_checker
(
  input wire logic       core_clk,
  input wire logic       rst_b,
  input wire logic       chip_select_n,
  input wire logic       internal_busy,
  input wire logic [3:0] lane_in,
  input wire logic [3:0] lane_out,
  input wire logic [3:0] lane_oe_n,
  input wire logic [7:0] status_reg_one,
  input wire logic [7:0] status_reg_two,
  input wire logic       standby,
  input wire logic       status_write_locked,
  input wire logic       array_write_locked,
  input wire logic       paused,
  input wire logic       status_wr,
  input wire logic       mem_wr
);
  // ====
  // Named steps; five cycles cover the pin synchroniser and output register
  wire lk = !lane_in[2] && !status_reg_two[0] && status_reg_one[7] && !status_reg_two[1];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence desel_s; chip_select_n[*5]; endsequence
  sequence idle_s; (chip_select_n && !internal_busy)[*5]; endsequence
  sequence lock_s; lk[*5]; endsequence
  sequence quad_s; status_reg_two[1][*5]; endsequence
  AST_DESEL_FLOAT: assert property (desel_s |-> lane_oe_n == 4'hF)
    else $error("lanes driven while deselected");
  AST_STANDBY: assert property (idle_s |-> standby)
    else $error("no standby when idle");
  AST_ACTIVE: assert property ((!chip_select_n)[*5] |-> !standby)
    else $error("standby while selected");
  AST_STATUS_LOCK: assert property (lock_s |-> status_write_locked && array_write_locked)
    else $error("lock missing");
  AST_NO_STATUS_WR: assert property (status_wr |-> !status_write_locked)
    else $error("status write while locked");
  AST_QUAD_UNLOCK: assert property (quad_s |-> !status_write_locked && !paused)
    else $error("protect or pause active in quad");
  AST_OE_MASK: assert property (lane_oe_n inside {4'hF, 4'hD, 4'hC, 4'h0})
    else $error("bad lane enable mask");
  AST_PAUSE_FREEZE: assert property (paused && $past(paused) |-> $stable(lane_out))
    else $error("lanes moved in pause");
  AST_WR_NO_DRIVE: assert property (mem_wr |-> lane_oe_n == 4'hF)
    else $error("lanes driven in write");
endmodule // serial_flash_pin_interface_checker

// ### spi_host_model.sv
// Behavioural host controller driving the flash pins
`timescale 1ns/1ps
module spi_host_model
(
  output logic       chip_select_n,
  output logic       serial_clock,
  output wire  [3:0] h_val,
  output wire  [3:0] h_en,
  input  wire  [3:0] lane_in
);
  // ====
  // Lanes 2 and 3 carry protect and pause levels outside quad phases
  logic       cpol = 1'b0;
  logic       wp_n = 1'b1;
  logic       hold_n = 1'b1;
  logic       w4 = 1'b0;
  logic [3:0] dv = 4'h0;
  logic [3:0] den = 4'h0;
  initial
  begin
    chip_select_n = 1'b0;
    serial_clock = 1'b0;
  end
  assign h_val = w4 ? dv : {hold_n, wp_n, dv[1:0]};
  assign h_en = w4 ? den : {2'b11, den[1:0]};
  // ====
  // Frame phases; clock stands still between frames
  task frame_on;
    serial_clock = cpol;
    #80;
    chip_select_n = 1'b0;
    #80;
  endtask
  task frame_off;
    serial_clock = cpol;
    den = 4'h0;
    w4 = 1'b0;
    #80;
    chip_select_n = 1'b1;
    #160;
  endtask
  task park(input logic v);
    serial_clock = v;
  endtask
  task automatic shift(input int w, input int n, input logic rd, input logic [31:0] d, output logic [31:0] q);
    logic [3:0] m;
    m = 4'hF >> (4 - w);
    q = 32'h0;
    w4 = (w == 4);
    den = rd ? 4'h0 : m;
    for (int i = n; i > 0; i -= w)
    begin
      serial_clock = 1'b0;
      dv = 4'(d >> (i - w)) & m;
      #80;
      serial_clock = 1'b1;
      q = (q << w) | ((w == 1) ? 32'(lane_in[1]) : 32'(lane_in & m));
      #80;
    end
  endtask
endmodule // spi_host_model

// ### serial_flash_pin_interface_bench.sv
// Self-checking bench for the flash pin engine
`timescale 1ns/1ps
module serial_flash_pin_interface_bench;
  // ====
  // Stimulus, pin wiring and memory stand-in
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  status_reg_one = 8'h00;
  logic [7:0]  status_reg_two = 8'h00;
  logic        pause_or_reset_select = 1'b0;
  logic        internal_busy = 1'b0;
  logic [7:0]  mem_rdata = 8'h00;
  logic        tgl = 1'b0;
  logic [23:0] wa;
  logic [7:0]  wd;
  logic [31:0] q;
  logic [7:0]  ops [4] = '{8'h03, 8'h0B, 8'h3B, 8'h6B};
  int          wid [4] = '{1, 1, 2, 4};
  int          sw_cnt = 0;
  int          cv_cnt = 0;
  int          bad_count = 0;
  int          num_checks = 0;
  wire [3:0]   lane_in, lane_out, lane_oe_n, h_val, h_en;
  wire [7:0]   cmd_code, mem_wdata;
  wire [23:0]  mem_addr;
  wire [1:0]   mem_space;
  wire         chip_select_n, serial_clock, standby, status_write_locked, array_write_locked, paused;
  wire         hw_reset, quad_command_mode, execute_from_flash, cmd_valid, xfer_end, mem_rd, mem_wr, status_wr;
  // Released data lanes toggle; protect and pause lanes have pull-ups
  assign lane_in = (~lane_oe_n & lane_out) | (lane_oe_n & ((h_en & h_val) | (~h_en & {2'b11, tgl, ~tgl})));
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    tgl <= ~tgl;
    if (mem_rd) mem_rdata <= mem_addr[7:0] ^ 8'h5A;
    if (mem_wr) {wa, wd} <= {mem_addr, mem_wdata};
    if (status_wr) sw_cnt <= sw_cnt + 1;
    if (cmd_valid) cv_cnt <= cv_cnt + 1;
  end
  spi_host_model host (.chip_select_n, .serial_clock, .h_val, .h_en, .lane_in);
  serial_flash_pin_interface DUT (.core_clk, .rst_b, .chip_select_n, .serial_clock, .lane_in, .lane_out,
    .lane_oe_n, .status_reg_one, .status_reg_two, .pause_or_reset_select, .internal_busy, .standby,
    .status_write_locked, .array_write_locked, .paused, .hw_reset, .quad_command_mode, .execute_from_flash,
    .cmd_valid, .cmd_code, .xfer_end, .mem_rd, .mem_wr, .status_wr, .mem_space, .mem_addr, .mem_wdata, .mem_rdata);
  // ====
  // Shared tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task send(input int w, input int n, input logic [31:0] d);
    host.shift(w, n, 1'b0, d, q);
  endtask
  task op1(input int w, input logic [15:0] op, input int n = 8);
    host.frame_on();
    send(w, n, op);
    host.frame_off();
    step(2);
  endtask
  task rd_byte(input logic [7:0] op, input int w, input logic [23:0] a);
    host.frame_on();
    send(1, 8, op);
    send(1, 24, a);
    if (op != 8'h03) host.shift(1, 8, 1'b1, 0, q);
    host.shift(w, 8, 1'b1, 0, q);
    host.frame_off();
    step(2);
    chk(cmd_code, op);
    chk(q[7:0], a[7:0] ^ 8'h5A);
  endtask
  task eb_tail(input logic [23:0] a, input logic [7:0] m);
    send(4, 32, {a, m});
    host.shift(4, 16, 1'b1, 0, q);
    host.shift(4, 8, 1'b1, 0, q);
    host.frame_off();
    step(2);
    chk(q[7:0], a[7:0] ^ 8'h5A);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ====
  // Scenarios
  task t_power;
    send(1, 8, 8'h9F);
    step(5);
    chk(cv_cnt, 0);
    chk(standby, 0);
    host.frame_off();
    step(6);
    chk(standby, 1);
    internal_busy = 1'b1;
    step(6);
    chk(standby, 0);
    internal_busy = 1'b0;
    $display("test power done");
  endtask
  task t_reads;
    status_reg_two = 8'h02;
    for (int i = 0; i < 4; i++) rd_byte(ops[i], wid[i], 24'h000010 + i);
    rd_byte(8'h48, 1, 24'h000020);
    chk(mem_space, 2'h2);
    host.frame_on();
    send(1, 8, 8'hEB);
    eb_tail(24'h000030, 8'h20);
    chk(execute_from_flash, 1);
    host.frame_on();
    eb_tail(24'h000031, 8'h00);
    chk(execute_from_flash, 0);
    host.frame_on();
    send(1, 8, 8'h02);
    send(1, 24, 24'h000040);
    send(1, 8, 8'hC3);
    host.frame_off();
    step(2);
    chk({wa, wd}, 32'h000040C3);
    status_reg_two = 8'h00;
    host.cpol = 1'b1;
    rd_byte(8'h03, 1, 24'h0000A0);
    host.cpol = 1'b0;
    $display("test reads done");
  endtask
  task t_lock;
    int c;
    status_reg_one = 8'h80;
    host.wp_n = 1'b0;
    step(8);
    chk({status_write_locked, array_write_locked}, 2'b11);
    c = sw_cnt;
    op1(1, 16'h0100, 16);
    chk(sw_cnt, c);
    host.wp_n = 1'b1;
    step(8);
    op1(1, 16'h0100, 16);
    chk(sw_cnt, c + 1);
    host.wp_n = 1'b0;
    status_reg_two = 8'h02;
    step(8);
    chk(status_write_locked, 0);
    {status_reg_one, status_reg_two, host.wp_n} = {16'h0000, 1'b1};
    $display("test lock done");
  endtask
  task t_pause;
    logic [3:0] hi;
    step(8);
    host.frame_on();
    send(1, 8, 8'h03);
    send(1, 24, 24'h000050);
    host.shift(1, 4, 1'b1, 0, q);
    hi = q[3:0];
    host.park(1'b0);
    step(10);
    host.hold_n = 1'b0;
    step(10);
    chk(paused, 1);
    host.shift(1, 2, 1'b1, 0, q);
    host.hold_n = 1'b1;
    step(10);
    chk(paused, 1);
    host.park(1'b0);
    step(10);
    chk(paused, 0);
    host.shift(1, 4, 1'b1, 0, q);
    host.frame_off();
    chk({hi, q[3:0]}, 8'h50 ^ 8'h5A);
    $display("test pause done");
  endtask
  task t_qpi;
    status_reg_two = 8'h02;
    op1(1, 8'h38);
    chk(quad_command_mode, 1);
    op1(4, 8'hFF);
    chk(quad_command_mode, 0);
    op1(1, 8'h38);
    op1(4, 8'h66);
    op1(4, 8'h99);
    chk(quad_command_mode, 0);
    op1(1, 8'h38);
    status_reg_two = 8'h00;
    pause_or_reset_select = 1'b1;
    host.hold_n = 1'b0;
    step(10);
    chk({hw_reset, quad_command_mode}, 2'b10);
    host.hold_n = 1'b1;
    pause_or_reset_select = 1'b0;
    step(10);
    $display("test quad command done");
  endtask
  initial
  begin
    repeat (10) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    step(5);
    t_power;
    t_reads;
    t_lock;
    t_pause;
    t_qpi;
    print_verdict;
  end
endmodule // serial_flash_pin_interface_bench

bind serial_flash_pin_interface serial_flash_pin_interface_checker chk_i (.core_clk, .rst_b, .chip_select_n,
  .internal_busy, .lane_in, .lane_out, .lane_oe_n, .status_reg_one, .status_reg_two, .standby,
  .status_write_locked, .array_write_locked, .paused, .status_wr, .mem_wr);
